// ---- hw/ps2d_pkg.sv ----
// Shared constants and types for the keyboard and mouse link device
package ps2d_pkg;

    // ==================== Timing ====================
    localparam int CLK_HZ       = 40_000_000;
    localparam int BIT_HALF_US  = 20;
    localparam int BIT_HALF_CYC = BIT_HALF_US * (CLK_HZ / 1_000_000);
    localparam int PKT_GAP_MS   = 50;
    localparam int PKT_GAP_CYC  = PKT_GAP_MS * (CLK_HZ / 1_000);
    localparam int HALF_W       = 12;
    localparam int GAP_W        = 24;

    // ==================== Frame ====================
    localparam int          FRAME_BITS = 11;
    localparam int          BIT_W      = 4;
    localparam logic [3:0]  BIT_START  = 4'h0;
    localparam logic [3:0]  BIT_PARITY = 4'h9;
    localparam logic [3:0]  BIT_STOP   = 4'hA;
    localparam logic [1:0]  PKT_LAST   = 2'h2;
    localparam logic        PIN_LOW    = 1'b0;

    // ==================== Host commands and replies ====================
    localparam logic [7:0] CMD_LED    = 8'hED;
    localparam logic [7:0] CMD_ECHO   = 8'hEE;
    localparam logic [7:0] CMD_RATE   = 8'hF3;
    localparam logic [7:0] CMD_RESEND = 8'hFE;
    localparam logic [7:0] CMD_RESET  = 8'hFF;
    localparam logic [7:0] REPLY_ACK  = 8'hFA;

    // ==================== Register map ====================
    localparam int         ADDR_W    = 5;
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_SCAN = 5'h04;
    localparam logic [4:0] ADDR_MOTX = 5'h08;
    localparam logic [4:0] ADDR_MOTY = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h10;

    localparam int CTRL_MOUSE  = 0;
    localparam int CTRL_MOVING = 1;
    localparam int CTRL_LBTN   = 2;
    localparam int CTRL_RBTN   = 3;
    localparam int CTRL_W      = 4;

    // ==================== Mouse status byte ====================
    localparam int ST_LEFT  = 0;
    localparam int ST_RIGHT = 1;
    localparam int ST_XS    = 4;
    localparam int ST_YS    = 5;
    localparam int ST_XV    = 6;
    localparam int ST_YV    = 7;

    localparam logic signed [15:0] AXIS_MAX = 16'sh00FF;
    localparam logic signed [15:0] AXIS_MIN = 16'shFF00;
    localparam logic [7:0]         SAT_POS  = 8'hFF;
    localparam logic [7:0]         SAT_NEG  = 8'h00;

    // ==================== Indicators ====================
    localparam int         LED_W     = 3;
    localparam int         LED_SCRL  = 0;
    localparam int         LED_NUM   = 1;
    localparam int         LED_CAPS  = 2;
    localparam logic [2:0] LED_RST   = 3'h0;
    localparam logic [7:0] RATE_RST  = 8'h00;

    // ==================== Types ====================
    typedef enum logic [1:0] {TX_IDLE, TX_CHECK, TX_HIGH, TX_LOW} ps2d_tx_e;
    typedef enum logic [1:0] {SRC_RESP, SRC_SCAN, SRC_MOUSE} ps2d_src_e;
    typedef enum logic [1:0] {ARG_NONE, ARG_LED, ARG_RATE} ps2d_arg_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } ps2d_bus_s;

    typedef struct packed {
        logic       ovf;
        logic       sign;
        logic [7:0] val;
    } ps2d_axis_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ps2d_rx_s;

endpackage : ps2d_pkg

// ---- hw/ps2d_dev.sv ----
// Keyboard and mouse end of the two-wire serial link
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps

module ps2d_dev #(
    parameter int HALF_CYC = ps2d_pkg::BIT_HALF_CYC,   // Half bit period in cycles
    parameter int GAP_CYC  = ps2d_pkg::PKT_GAP_CYC     // Packet repeat interval in cycles
) (
    input  wire logic                clk_sys_i,      // System clock
    input  wire logic                reset_i,        // Async reset, active high
    input  wire ps2d_pkg::ps2d_bus_s bus_i,          // Register request
    output logic [31:0]              rdata_o,        // Read data, cycle after read
    input  wire ps2d_pkg::ps2d_rx_s  rx_i,           // Host command byte
    input  wire logic                ps2_clk_i,      // Link clock pin level
    output logic                     ps2_clk_o,      // Link clock drive value
    output logic                     ps2_clk_oe_o,   // Link clock pulled low
    input  wire logic                ps2_dat_i,      // Link data pin level
    output logic                     ps2_dat_o,      // Link data drive value
    output logic                     ps2_dat_oe_o,   // Link data pulled low
    output logic [ps2d_pkg::LED_W-1:0] leds_o,       // Indicator states
    output logic                     busy_o          // Frame in progress
);

    // ==================== State ====================
    typedef struct packed {
        logic                         clk_meta;
        logic                         clk_sync;
        logic                         dat_meta;
        logic                         dat_sync;
        logic [ps2d_pkg::CTRL_W-1:0]  ctrl;
        logic [15:0]                  motx;
        logic [15:0]                  moty;
        logic [ps2d_pkg::LED_W-1:0]   leds;
        logic [7:0]                   rate;
        ps2d_pkg::ps2d_arg_e          arg;
        logic                         resp_pend;
        logic [7:0]                   resp;
        logic                         scan_pend;
        logic [7:0]                   scan;
        logic [7:0]                   last_scan;
        logic                         pkt_active;
        logic [1:0]                   pkt_idx;
        logic [23:0]                  pkt;
        logic [ps2d_pkg::GAP_W-1:0]   gap;
        ps2d_pkg::ps2d_tx_e           tx;
        ps2d_pkg::ps2d_src_e          src;
        logic [7:0]                   tx_byte;
        logic [ps2d_pkg::BIT_W-1:0]   bit_idx;
        logic [ps2d_pkg::HALF_W-1:0]  cnt;
        logic                         clk_oe;
        logic                         dat_oe;
        logic [31:0]                  rdata;
    } ps2d_state_s;

    localparam logic [ps2d_pkg::HALF_W-1:0] HALF_LOAD = ps2d_pkg::HALF_W'(HALF_CYC - 1);
    localparam logic [ps2d_pkg::GAP_W-1:0]  GAP_LOAD  = ps2d_pkg::GAP_W'(GAP_CYC - 1);

    ps2d_state_s s_r;
    ps2d_state_s s_nxt;

    // ==================== Functions ====================
    // Level of one frame position
    function automatic logic frame_bit(input logic [7:0] b, input logic [3:0] idx);
        logic v;
        v = 1'b1;
        if (idx == ps2d_pkg::BIT_START) begin
            v = 1'b0;
        end else if (idx < ps2d_pkg::BIT_PARITY) begin
            v = b[3'(idx - 4'h1)];
        end else if (idx == ps2d_pkg::BIT_PARITY) begin
            v = ~^b;
        end else begin
            v = 1'b1;
        end
        return v;
    endfunction : frame_bit

    // Clamp a signed motion value into sign, overflow and byte
    function automatic ps2d_pkg::ps2d_axis_s to_axis(input logic signed [15:0] v);
        ps2d_pkg::ps2d_axis_s a;
        a.sign = v[15];
        a.ovf  = (v > ps2d_pkg::AXIS_MAX) || (v < ps2d_pkg::AXIS_MIN);
        if (a.ovf) begin
            a.val = v[15] ? ps2d_pkg::SAT_NEG : ps2d_pkg::SAT_POS;
        end else begin
            a.val = v[7:0];
        end
        return a;
    endfunction : to_axis

    // Word returned for a register read; unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [ps2d_pkg::ADDR_W-1:0] a,
                                              input ps2d_state_s                 s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == ps2d_pkg::ADDR_CTRL) begin
            w = {28'h000_0000, s.ctrl};
        end else if (a == ps2d_pkg::ADDR_SCAN) begin
            w = {24'h00_0000, s.scan};
        end else if (a == ps2d_pkg::ADDR_MOTX) begin
            w = {16'h0000, s.motx};
        end else if (a == ps2d_pkg::ADDR_MOTY) begin
            w = {16'h0000, s.moty};
        end else if (a == ps2d_pkg::ADDR_STAT) begin
            w = {8'h00, s.last_scan, s.rate, 2'h0,
                 s.tx != ps2d_pkg::TX_IDLE, s.scan_pend,
                 s.resp_pend, s.leds};
        end
        return w;
    endfunction : read_word

    // ==================== Next state ====================
    always_comb begin
        ps2d_pkg::ps2d_axis_s ax;
        ps2d_pkg::ps2d_axis_s ay;
        logic [7:0]           status;
        logic                 is_mouse;
        s_nxt    = s_r;
        ax       = to_axis(s_r.motx);
        ay       = to_axis(s_r.moty);
        status   = 8'h00;
        is_mouse = s_r.ctrl[ps2d_pkg::CTRL_MOUSE];

        // Two-stage pin synchronisers
        s_nxt.clk_meta = ps2_clk_i;
        s_nxt.clk_sync = s_r.clk_meta;
        s_nxt.dat_meta = ps2_dat_i;
        s_nxt.dat_sync = s_r.dat_meta;

        // Mouse status byte
        status[ps2d_pkg::ST_LEFT]  = s_r.ctrl[ps2d_pkg::CTRL_LBTN];
        status[ps2d_pkg::ST_RIGHT] = s_r.ctrl[ps2d_pkg::CTRL_RBTN];
        status[ps2d_pkg::ST_XS]    = ax.sign;
        status[ps2d_pkg::ST_YS]    = ay.sign;
        status[ps2d_pkg::ST_XV]    = ax.ovf;
        status[ps2d_pkg::ST_YV]    = ay.ovf;

        // Repeat interval
        if (s_r.gap != '0) begin
            s_nxt.gap = s_r.gap - 1'b1;
        end

        // ==================== Transmitter ====================
        case (s_r.tx)
            ps2d_pkg::TX_IDLE: begin
                if (s_r.resp_pend) begin
                    s_nxt.tx_byte = s_r.resp;
                    s_nxt.src     = ps2d_pkg::SRC_RESP;
                    s_nxt.tx      = ps2d_pkg::TX_CHECK;
                end else if (!is_mouse && s_r.scan_pend) begin
                    s_nxt.tx_byte = s_r.scan;
                    s_nxt.src     = ps2d_pkg::SRC_SCAN;
                    s_nxt.tx      = ps2d_pkg::TX_CHECK;
                end else if (is_mouse && s_r.pkt_active) begin
                    s_nxt.tx_byte = s_r.pkt[s_r.pkt_idx*8 +: 8];
                    s_nxt.src     = ps2d_pkg::SRC_MOUSE;
                    s_nxt.tx      = ps2d_pkg::TX_CHECK;
                end
                s_nxt.cnt = HALF_LOAD;
            end
            ps2d_pkg::TX_CHECK: begin
                // Any low level on either line restarts the idle count
                if (!(s_r.clk_sync && s_r.dat_sync)) begin
                    s_nxt.cnt = HALF_LOAD;
                end else if (s_r.cnt == '0) begin
                    s_nxt.tx      = ps2d_pkg::TX_HIGH;
                    s_nxt.bit_idx = ps2d_pkg::BIT_START;
                    s_nxt.cnt     = HALF_LOAD;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            ps2d_pkg::TX_HIGH: begin
                // Clock released; pin level judged only at end of half
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end else if (!s_r.clk_sync) begin
                    // Host holds clock low: drop the frame, retry later
                    s_nxt.tx  = ps2d_pkg::TX_CHECK;
                    s_nxt.cnt = HALF_LOAD;
                end else begin
                    s_nxt.tx  = ps2d_pkg::TX_LOW;
                    s_nxt.cnt = HALF_LOAD;
                end
            end
            ps2d_pkg::TX_LOW: begin
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end else if (s_r.bit_idx == ps2d_pkg::BIT_STOP) begin
                    s_nxt.tx = ps2d_pkg::TX_IDLE;
                    case (s_r.src)
                        ps2d_pkg::SRC_RESP: begin
                            s_nxt.resp_pend = 1'b0;
                        end
                        ps2d_pkg::SRC_SCAN: begin
                            s_nxt.scan_pend = 1'b0;
                            s_nxt.last_scan = s_r.tx_byte;
                        end
                        default: begin
                            s_nxt.pkt_idx = s_r.pkt_idx + 1'b1;
                            if (s_r.pkt_idx == ps2d_pkg::PKT_LAST) begin
                                s_nxt.pkt_active = 1'b0;
                                s_nxt.pkt_idx    = '0;
                                s_nxt.gap        = GAP_LOAD;
                            end
                        end
                    endcase
                end else begin
                    s_nxt.bit_idx = s_r.bit_idx + 1'b1;
                    s_nxt.tx      = ps2d_pkg::TX_HIGH;
                    s_nxt.cnt     = HALF_LOAD;
                end
            end
            default: begin
                s_nxt.tx = ps2d_pkg::TX_IDLE;
            end
        endcase

        // ==================== Mouse packets ====================
        if (is_mouse && s_r.ctrl[ps2d_pkg::CTRL_MOVING] && !s_r.pkt_active
            && s_r.gap == '0 && s_r.tx == ps2d_pkg::TX_IDLE) begin
            s_nxt.pkt_active = 1'b1;
            s_nxt.pkt_idx    = '0;
            s_nxt.pkt        = {ay.val, ax.val, status};
        end

        // ==================== Host commands ====================
        // Command port is ignored in mouse mode
        if (rx_i.valid && !is_mouse) begin
            if (s_r.arg == ps2d_pkg::ARG_LED) begin
                s_nxt.leds = rx_i.data[ps2d_pkg::LED_W-1:0];
                s_nxt.arg  = ps2d_pkg::ARG_NONE;
            end else if (s_r.arg == ps2d_pkg::ARG_RATE) begin
                s_nxt.rate = rx_i.data;
                s_nxt.arg  = ps2d_pkg::ARG_NONE;
            end else begin
                case (rx_i.data)
                    ps2d_pkg::CMD_LED: begin
                        s_nxt.resp      = ps2d_pkg::REPLY_ACK;
                        s_nxt.resp_pend = 1'b1;
                        s_nxt.arg       = ps2d_pkg::ARG_LED;
                    end
                    ps2d_pkg::CMD_ECHO: begin
                        s_nxt.resp      = ps2d_pkg::CMD_ECHO;
                        s_nxt.resp_pend = 1'b1;
                    end
                    ps2d_pkg::CMD_RATE: begin
                        s_nxt.resp      = ps2d_pkg::REPLY_ACK;
                        s_nxt.resp_pend = 1'b1;
                        s_nxt.arg       = ps2d_pkg::ARG_RATE;
                    end
                    ps2d_pkg::CMD_RESEND: begin
                        s_nxt.resp      = s_r.last_scan;
                        s_nxt.resp_pend = 1'b1;
                    end
                    ps2d_pkg::CMD_RESET: begin
                        s_nxt.leds      = ps2d_pkg::LED_RST;
                        s_nxt.rate      = ps2d_pkg::RATE_RST;
                        s_nxt.scan_pend = 1'b0;
                        s_nxt.arg       = ps2d_pkg::ARG_NONE;
                    end
                    default: begin
                        s_nxt.arg = ps2d_pkg::ARG_NONE;
                    end
                endcase
            end
        end

        // ==================== Register bus ====================
        // Read data stand for one cycle only
        s_nxt.rdata = '0;
        if (bus_i.wr) begin
            if (bus_i.addr == ps2d_pkg::ADDR_CTRL) begin
                s_nxt.ctrl = bus_i.wdata[ps2d_pkg::CTRL_W-1:0];
            end else if (bus_i.addr == ps2d_pkg::ADDR_SCAN) begin
                s_nxt.scan      = bus_i.wdata[7:0];
                s_nxt.scan_pend = 1'b1;
            end else if (bus_i.addr == ps2d_pkg::ADDR_MOTX) begin
                s_nxt.motx = bus_i.wdata[15:0];
            end else if (bus_i.addr == ps2d_pkg::ADDR_MOTY) begin
                s_nxt.moty = bus_i.wdata[15:0];
            end
        end
        if (bus_i.rd) begin
            s_nxt.rdata = read_word(bus_i.addr, s_r);
        end

        // Open-drain drives from the next bit position
        s_nxt.clk_oe = (s_nxt.tx == ps2d_pkg::TX_LOW);
        s_nxt.dat_oe = (s_nxt.tx == ps2d_pkg::TX_HIGH || s_nxt.tx == ps2d_pkg::TX_LOW)
                       && !frame_bit(s_nxt.tx_byte, s_nxt.bit_idx);
    end

    // ==================== Registers ====================
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_r           <= '0;
            s_r.clk_meta  <= 1'b1;
            s_r.clk_sync  <= 1'b1;
            s_r.dat_meta  <= 1'b1;
            s_r.dat_sync  <= 1'b1;
            s_r.leds      <= ps2d_pkg::LED_RST;
            s_r.rate      <= ps2d_pkg::RATE_RST;
            s_r.arg       <= ps2d_pkg::ARG_NONE;
            s_r.tx        <= ps2d_pkg::TX_IDLE;
            s_r.src       <= ps2d_pkg::SRC_RESP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================== Outputs ====================
    assign rdata_o      = s_r.rdata;
    assign ps2_clk_o    = ps2d_pkg::PIN_LOW;
    assign ps2_clk_oe_o = s_r.clk_oe;
    assign ps2_dat_o    = ps2d_pkg::PIN_LOW;
    assign ps2_dat_oe_o = s_r.dat_oe;
    assign leds_o       = s_r.leds;
    assign busy_o       = (s_r.tx != ps2d_pkg::TX_IDLE);

endmodule : ps2d_dev

// ---- tb/ps2d_checker.sv ----
// Port checks for the keyboard and mouse link device
`timescale 1ns/1ps

module ps2d_checker #(
    parameter int HALF_CYC = 8,   // Half bit period in cycles
    parameter int GAP_CYC  = 200  // Packet repeat interval
) (
    input wire logic                clk_sys_i,    // System clock
    input wire logic                reset_i,      // Async reset
    input wire ps2d_pkg::ps2d_bus_s bus_i,        // Register request
    input wire logic [31:0]         rdata_o,      // Read data
    input wire ps2d_pkg::ps2d_rx_s  rx_i,         // Host byte
    input wire logic                ps2_clk_i,    // Clock pin
    input wire logic                ps2_clk_o,    // Clock value
    input wire logic                ps2_clk_oe_o, // Clock pull
    input wire logic                ps2_dat_i,    // Data pin
    input wire logic                ps2_dat_o,    // Data value
    input wire logic                ps2_dat_oe_o, // Data pull
    input wire logic [2:0]          leds_o,       // Indicators
    input wire logic                busy_o        // Frame busy
);
    logic [15:0] lo_cnt_r;
    logic [15:0] idle_cnt_r;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            lo_cnt_r   <= '0;
            idle_cnt_r <= '0;
        end else begin
            lo_cnt_r   <= ps2_clk_oe_o ? lo_cnt_r + 16'h0001 : '0;
            idle_cnt_r <= (ps2_clk_i && ps2_dat_i) ? idle_cnt_r + {15'h0000, ~&idle_cnt_r} : '0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // ==================== Assertions ====================
    idle_lines_a: assert property (!busy_o && !$past(busy_o) |-> !ps2_clk_oe_o && !ps2_dat_oe_o)
        else $error("Line pulled while idle");
    open_drain_a: assert property (ps2_clk_o == 1'b0 && ps2_dat_o == 1'b0)
        else $error("Drive value not low");
    inhibit_hold_a: assert property ((!ps2_clk_i && !ps2_clk_oe_o) [*4] |=> !$rose(ps2_dat_oe_o))
        else $error("Data pulled during inhibit");
    low_half_a: assert property ($fell(ps2_clk_oe_o) |-> lo_cnt_r == HALF_CYC)
        else $error("Clock low half wrong length");
    stop_bit_a: assert property ($fell(busy_o) |-> $past(ps2_dat_oe_o, 2) == 1'b0)
        else $error("Stop bit not high");
    start_idle_a: assert property ($rose(ps2_dat_oe_o) && !$past(ps2_clk_oe_o)
        && !$past(ps2_clk_oe_o, 2) |-> idle_cnt_r >= HALF_CYC)
        else $error("Frame started without idle lines");
    read_data_a: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
        else $error("Read data outside answer cycle");
    leds_change_a: assert property ($changed(leds_o) |-> $past(rx_i.valid))
        else $error("Indicators changed without host byte");
endmodule : ps2d_checker

bind ps2d_dev ps2d_checker #(.HALF_CYC(HALF_CYC), .GAP_CYC(GAP_CYC)) u_ps2d_checker (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o), .rx_i(rx_i),
    .ps2_clk_i(ps2_clk_i), .ps2_clk_o(ps2_clk_o), .ps2_clk_oe_o(ps2_clk_oe_o),
    .ps2_dat_i(ps2_dat_i), .ps2_dat_o(ps2_dat_o), .ps2_dat_oe_o(ps2_dat_oe_o),
    .leds_o(leds_o), .busy_o(busy_o));

// ---- tb/ps2d_host_model.sv ----
// Host side model: receives link frames and checks their framing
`timescale 1ns/1ps

module ps2d_host_model (
    input wire logic clk_sys_i, // System clock
    input wire logic clk_pin_i, // Link clock level
    input wire logic dat_pin_i, // Link data level
    input wire logic inhibit_i  // Host holds clock low
);
    logic [10:0] sh_r = '0;
    int          nbit_r = 0;
    logic        clk_d_r = 1'b1;
    logic [7:0]  rxq[$];
    int          n_bad = 0;

    always @(posedge clk_sys_i) begin
        clk_d_r <= clk_pin_i;
        if (inhibit_i) begin
            nbit_r <= 0;
        end else if (clk_d_r && !clk_pin_i) begin
            sh_r   <= {dat_pin_i, sh_r[10:1]};
            nbit_r <= nbit_r + 1;
        end
        if (nbit_r == 11) begin
            nbit_r <= 0;
            if (sh_r[0] || !sh_r[10] || !(^sh_r[9:1])) n_bad <= n_bad + 1;
            else rxq.push_back(sh_r[8:1]);
        end
    end
endmodule : ps2d_host_model

// ---- tb/ps2d_tb_top.sv ----
// Testbench for the keyboard and mouse link device
`timescale 1ns/1ps

module ps2d_tb_top;
    localparam int HALF = 4;
    localparam int GAP  = 200;
    logic                clk_sys_i, reset_i, inhibit, busy, clk_oe, dat_oe, clk_pin, dat_pin;
    ps2d_pkg::ps2d_bus_s bus;
    ps2d_pkg::ps2d_rx_s  rx;
    logic [31:0]         rdata, v;
    logic [2:0]          leds;
    int                  n_errors, n_compared;
    logic [31:0]         mx[2] = '{32'h0000_012C, 32'hFFFF_FFFD};
    logic [31:0]         my[2] = '{32'hFFFF_FFFB, 32'h0000_0190};
    logic [31:0]         mc[2] = '{32'h0000_0007, 32'h0000_000B};
    logic [23:0]         me[2] = '{24'h61_FFFB, 24'h92_FDFF};

    // Open-drain lines with pull-ups
    assign clk_pin = !(clk_oe | inhibit);
    assign dat_pin = !dat_oe;

    ps2d_dev #(.HALF_CYC(HALF), .GAP_CYC(GAP)) u_ps2d_dev (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata), .rx_i(rx),
        .ps2_clk_i(clk_pin), .ps2_clk_o(), .ps2_clk_oe_o(clk_oe), .ps2_dat_i(dat_pin),
        .ps2_dat_o(), .ps2_dat_oe_o(dat_oe), .leds_o(leds), .busy_o(busy));
    ps2d_host_model u_ps2d_host_model (.clk_sys_i(clk_sys_i), .clk_pin_i(clk_pin),
        .dat_pin_i(dat_pin), .inhibit_i(inhibit));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task complete_run();
        $display("Compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task wr(logic [4:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask : wr

    task rd(logic [4:0] a);
        @(posedge clk_sys_i);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task cmd(logic [7:0] b);
        @(posedge clk_sys_i);
        rx <= '{valid: 1'b1, data: b};
        @(posedge clk_sys_i);
        rx.valid <= 1'b0;
    endtask : cmd

    task get_byte(string what, logic [7:0] exp);
        int k;
        for (k = 0; k < 2000 && u_ps2d_host_model.rxq.size() == 0; k++) @(posedge clk_sys_i);
        if (u_ps2d_host_model.rxq.size() == 0) begin
            n_errors++;
            $display("ERROR %s expected %h seen none", what, exp);
            complete_run();
        end else begin
            check(what, exp, u_ps2d_host_model.rxq.pop_front());
        end
    endtask : get_byte

    initial begin
        reset_i = 1'b1;
        bus = '0;
        rx = '0;
        inhibit = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(ps2d_pkg::ADDR_STAT);
        check("status reset", 32'h0000_0000, v);
        rd(5'h14);
        check("unmapped read", 32'h0000_0000, v);
        $display("Test reset done");
        cmd(ps2d_pkg::CMD_ECHO);
        get_byte("echo", ps2d_pkg::CMD_ECHO);
        cmd(ps2d_pkg::CMD_LED);
        get_byte("led ack", ps2d_pkg::REPLY_ACK);
        cmd(8'hFD);
        repeat (2) @(posedge clk_sys_i);
        check("leds", 32'h0000_0005, leds);
        cmd(ps2d_pkg::CMD_RATE);
        get_byte("rate ack", ps2d_pkg::REPLY_ACK);
        cmd(8'h5A);
        rd(ps2d_pkg::ADDR_STAT);
        check("rate", 32'h0000_005A, v[15:8]);
        $display("Test commands done");
        wr(ps2d_pkg::ADDR_SCAN, 32'h0000_003C);
        get_byte("scan", 8'h3C);
        cmd(ps2d_pkg::CMD_RESEND);
        get_byte("resend", 8'h3C);
        inhibit <= 1'b1;
        wr(ps2d_pkg::ADDR_SCAN, 32'h0000_0081);
        repeat (60) @(posedge clk_sys_i);
        check("inhibited", 32'h0000_0000, {dat_oe, 31'(u_ps2d_host_model.rxq.size())});
        inhibit <= 1'b0;
        get_byte("after inhibit", 8'h81);
        cmd(ps2d_pkg::CMD_RESET);
        repeat (4) @(posedge clk_sys_i);
        rd(ps2d_pkg::ADDR_STAT);
        check("status after reset", 32'h0000_0000, v[15:0]);
        $display("Test scan done");
        for (int c = 0; c < 2; c++) begin
            wr(ps2d_pkg::ADDR_MOTX, mx[c]);
            wr(ps2d_pkg::ADDR_MOTY, my[c]);
            wr(ps2d_pkg::ADDR_CTRL, mc[c]);
            for (int p = 0; p < 2; p++) begin
                get_byte("mouse status", me[c][23:16]);
                get_byte("mouse x", me[c][15:8]);
                get_byte("mouse y", me[c][7:0]);
            end
        end
        wr(ps2d_pkg::ADDR_CTRL, 32'h0000_0001);
        cmd(ps2d_pkg::CMD_ECHO);
        repeat (GAP + 300) @(posedge clk_sys_i);
        check("mouse quiet", 32'h0000_0000, {busy, 31'(u_ps2d_host_model.rxq.size())});
        check("frame errors", 32'h0000_0000, u_ps2d_host_model.n_bad);
        $display("Test mouse done");
        complete_run();
    end
endmodule : ps2d_tb_top
